// [src/pmic_poc_cfg.svh]
// constants for the power-on control block: offsets, fields, reset values, timing
`ifndef PMIC_POC_CFG_SVH
`define PMIC_POC_CFG_SVH

// system clock
`define CLK_HZ            125000000
`define CLK_PERIOD_NS     8

// rails: three step-down converters and two linear regulators
`define RAIL_COUNT        5
// start-up order, step 0 in the low bits, one rail index per 3-bit slot
`define START_ORDER       {3'h4, 3'h3, 3'h2, 3'h1, 3'h0}

// timing, each in its own unit with the figure as printed
`define DEBOUNCE_MS       20
`define SEQ_STEP_US       100
`define LONG_PRESS_S      15
`define LONG_PULSE_MS     0.5
`define DELAY0_MS         1
`define DELAY1_MS         10
`define DELAY2_MS         20
`define DELAY3_MS         100

// register byte offsets
`define OFS_CTRL          8'h00
`define OFS_FAULT_MASK    8'h04
`define OFS_STATUS        8'h08
`define OFS_IRQ_STATUS    8'h0C
`define OFS_IRQ_MASK      8'h10

// control register fields
`define CTRL_LONG_EN_BIT  0
`define CTRL_DELAY_LSB    1
`define CTRL_LED_LVL_BIT  3
`define CTRL_WIDTH        4

// reset values
`define CTRL_RESET        4'h0
`define FAULT_MASK_RESET  5'h1F
`define IRQ_MASK_RESET    5'h00

// interrupt bit positions
`define IRQ_POWERED_UP    0
`define IRQ_POWERED_DOWN  1
`define IRQ_LONG_PRESS    2
`define IRQ_SUPPLY_FAULT  3
`define IRQ_BUTTON_PRESS  4
`define IRQ_COUNT         5

`endif

// [src/pmic_poc_pkg.sv]
// types shared by the power-on control modules
package pmic_poc_pkg;
`include "pmic_poc_cfg.svh"

   typedef enum logic [1:0] {PWR_OFF, PWR_RAMP, PWR_ON} pwr_state_type;

   typedef struct packed {
      logic       ledLevel;
      logic [1:0] delaySel;
      logic       longPressEn;
   } ctrl_type;

   typedef struct packed {
      logic        stable;
      logic [31:0] cnt;
   } debounce_state_type;

   typedef struct packed {
      logic        released;
      logic [31:0] cnt;
   } delay_state_type;

   typedef struct packed {
      pwr_state_type           pwrState;
      logic [`RAIL_COUNT-1:0]  railOn;
      logic [2:0]              step;
      logic [31:0]             stepCnt;
      logic [31:0]             pressCnt;
      logic                    pressFired;
      logic [31:0]             pulseCnt;
      ctrl_type                ctrl;
      logic [`RAIL_COUNT-1:0]  faultMask;
      logic [`IRQ_COUNT-1:0]   irqStatus;
      logic [`IRQ_COUNT-1:0]   irqMask;
      logic [31:0]             rdata;
      logic                    echoOe;
      logic                    supplyOkOe;
      logic                    resetOe;
      logic                    ledSelA;
      logic                    ledSelB;
      logic                    prevPressed;
      logic                    prevOkRel;
   } poc_state_type;

endpackage : pmic_poc_pkg

// [src/debounce_filter.sv]
// debounce filter for an active-low push-button level
`timescale 1ns/1ps
module debounce_filter
   import pmic_poc_pkg::*;
#(
   parameter logic [31:0] LIMIT = 32'h0000_0010
) (
   input  wire logic clk_sys,
   input  wire logic rst,
   input  wire logic rawN,
   output      logic stableN
);
   debounce_state_type s_reg;
   debounce_state_type s_next;

   // the output follows the input only after it stayed different for LIMIT cycles
   always_comb begin
      s_next = s_reg;
      if (rawN == s_reg.stable) begin
         s_next.cnt = 32'h0;
      end else if (s_reg.cnt >= LIMIT - 32'h1) begin
         s_next.stable = rawN;
         s_next.cnt    = 32'h0;
      end else begin
         s_next.cnt = s_reg.cnt + 32'h1;
      end
   end

   // released is the safe state out of reset
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         s_reg <= '{stable: 1'b1, cnt: 32'h0};
      end else begin
         s_reg <= s_next;
      end
   end

   assign stableN = s_reg.stable;
endmodule : debounce_filter

// [src/release_delay.sv]
// release timer: output rises a chosen number of cycles after hold drops
`timescale 1ns/1ps
module release_delay
   import pmic_poc_pkg::*;
(
   input  wire logic        clk_sys,
   input  wire logic        rst,
   input  wire logic        hold,
   input  wire logic [31:0] limit,
   output      logic        released
);
   delay_state_type s_reg;
   delay_state_type s_next;

   // any hold restarts the wait, so a glitching source never releases early
   always_comb begin
      s_next = s_reg;
      if (hold) begin
         s_next.cnt      = 32'h0;
         s_next.released = 1'b0;
      end else if (!s_reg.released) begin
         if (s_reg.cnt >= limit - 32'h1) begin
            s_next.released = 1'b1;
         end else begin
            s_next.cnt = s_reg.cnt + 32'h1;
         end
      end
   end

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         s_reg <= '{released: 1'b0, cnt: 32'h0};
      end else begin
         s_reg <= s_next;
      end
   end

   assign released = s_reg.released;
endmodule : release_delay

// [src/pmic_power_on_control.sv]
// power-on control: button sequencing, hold-on, power-good, reset, led current select
`timescale 1ns/1ps
module pmic_power_on_control
   import pmic_poc_pkg::*;
#(
   parameter logic [31:0] DEBOUNCE_CYCLES = 32'(64'(`DEBOUNCE_MS) * 64'(`CLK_HZ) / 64'd1000),
   parameter logic [31:0] SEQ_STEP_CYCLES = 32'(64'(`SEQ_STEP_US) * 64'(`CLK_HZ) / 64'd1000000),
   parameter logic [31:0] LONG_PRESS_CYCLES = 32'(64'(`LONG_PRESS_S) * 64'(`CLK_HZ)),
   parameter logic [31:0] LONG_PULSE_CYCLES = 32'($rtoi(`LONG_PULSE_MS * `CLK_HZ / 1000.0)),
   parameter logic [31:0] DELAY0_CYCLES = 32'(64'(`DELAY0_MS) * 64'(`CLK_HZ) / 64'd1000),
   parameter logic [31:0] DELAY1_CYCLES = 32'(64'(`DELAY1_MS) * 64'(`CLK_HZ) / 64'd1000),
   parameter logic [31:0] DELAY2_CYCLES = 32'(64'(`DELAY2_MS) * 64'(`CLK_HZ) / 64'd1000),
   parameter logic [31:0] DELAY3_CYCLES = 32'(64'(`DELAY3_MS) * 64'(`CLK_HZ) / 64'd1000)
) (
   input  wire logic                   clk_sys,
   input  wire logic                   rst,
   // register port
   input  wire logic [7:0]             regAddr,
   input  wire logic [31:0]            regWrData,
   input  wire logic                   regWrite,
   input  wire logic                   regRead,
   output      logic [31:0]            regRdData,
   // button, processor hold-on, comparator and rail faults
   input  wire logic                   pushButtonN,
   input  wire logic                   holdOn,
   input  wire logic                   thresholdLow,
   input  wire logic [`RAIL_COUNT-1:0] railFault,
   // rail enables
   output      logic [`RAIL_COUNT-1:0] railEnable,
   // open-drain outputs: level and enable
   output      logic                   buttonEchoOut,
   output      logic                   buttonEchoOe,
   output      logic                   supplyOkOut,
   output      logic                   supplyOkOe,
   output      logic                   resetOutN,
   output      logic                   resetOe,
   // led current-set resistor select
   output      logic                   ledCurrentSetA,
   output      logic                   ledCurrentSetB,
   // interrupt
   output      logic                   irq
);

   ////////////////////////////////////////////////////////////////////////////////////////
   // declarations

   // start-up order as 3-bit rail indices, step 0 in the low bits
   localparam logic [3*`RAIL_COUNT-1:0] START_ORDER = `START_ORDER;
   localparam logic [2:0]              LAST_STEP   = 3'(`RAIL_COUNT);

   poc_state_type          s_reg;
   poc_state_type          s_next;
   logic                   btnStableN;
   logic                   pressed;
   logic                   okHold;
   logic                   okReleased;
   logic                   rstHold;
   logic                   rstReleased;
   logic [31:0]            delayLimit;
   logic [`IRQ_COUNT-1:0]  events;
   logic [`IRQ_COUNT-1:0]  irqClear;
   logic [2:0]             railIdx;
   logic [31:0]            statusWord;

   ////////////////////////////////////////////////////////////////////////////////////////
   // button filter

   // every use of the button goes through the filter, never the raw pin
   // the trade: every action lags the press by the filter interval
   debounce_filter #(
      .LIMIT   (DEBOUNCE_CYCLES)
   ) u_debounce (
      .clk_sys (clk_sys),
      .rst     (rst),
      .rawN    (pushButtonN),
      .stableN (btnStableN)
   );

   // the rest of the block works with an active-high press
   assign pressed = ~btnStableN;

   ////////////////////////////////////////////////////////////////////////////////////////
   // release delays for power-good and reset

   // one selectable delay serves both outputs
   // a new selection acts at once on a count already running
   always_comb begin
      unique case (s_reg.ctrl.delaySel)
         2'h0:    delayLimit = DELAY0_CYCLES;
         2'h1:    delayLimit = DELAY1_CYCLES;
         2'h2:    delayLimit = DELAY2_CYCLES;
         2'h3:    delayLimit = DELAY3_CYCLES;
      endcase
   end

   // power-good holds while not fully on or a selected rail faults
   // an unfinished start-up counts as a fault, so power-good only leads reset while the comparator holds reset
   assign okHold = (s_reg.pwrState != PWR_ON) | (|(railFault & s_reg.faultMask));

   release_delay u_ok_delay (
      .clk_sys  (clk_sys),
      .rst      (rst),
      .hold     (okHold),
      .limit    (delayLimit),
      .released (okReleased)
   );

   // reset holds while the comparator is low, and while the rails are not all up
   // the comparator alone can hold reset in an otherwise healthy system
   assign rstHold = thresholdLow | (s_reg.pwrState != PWR_ON);

   release_delay u_rst_delay (
      .clk_sys  (clk_sys),
      .rst      (rst),
      .hold     (rstHold),
      .limit    (delayLimit),
      .released (rstReleased)
   );

   // status word as software sees it; live pins sit beside the registered state
   assign statusWord = {19'h0, pressed, holdOn, thresholdLow, okReleased, rstReleased,
                        s_reg.railOn, 1'b0, s_reg.pwrState};

   ////////////////////////////////////////////////////////////////////////////////////////
   // next state

   always_comb begin
      s_next   = s_reg;
      events   = '0;
      irqClear = '0;
      railIdx  = 3'h0;

      // read data stand for one cycle only, zero otherwise
      // a zeroed bus lets several blocks share one or-ed read path
      s_next.rdata = 32'h0;

      // power sequencing
      unique case (s_reg.pwrState)
         PWR_OFF: begin
            // a ramp always begins from all rails off
            if (pressed) begin
               s_next.pwrState = PWR_RAMP;
               s_next.step     = 3'h0;
               s_next.stepCnt  = 32'h0;
               s_next.railOn   = '0;
            end
         end
         PWR_RAMP: begin
            // one rail per step, the step interval between successive rails
            if (s_reg.stepCnt != 32'h0) begin
               s_next.stepCnt = s_reg.stepCnt - 32'h1;
            end else if (s_reg.step < LAST_STEP) begin
               railIdx                 = START_ORDER[3*s_reg.step +: 3];
               s_next.railOn[railIdx]  = 1'b1;
               s_next.step             = s_reg.step + 3'h1;
               // preloaded one short, since the reload cycle counts too
               s_next.stepCnt          = SEQ_STEP_CYCLES - 32'h1;
            end else begin
               s_next.pwrState                = PWR_ON;
               events[`IRQ_POWERED_UP]        = 1'b1;
            end
         end
         PWR_ON: begin
            // rails stay as they are; only the shutdown test below drops them
            s_next.railOn = s_reg.railOn;
         end
         default: begin
            // the unused code falls back to off with every rail dropped
            s_next.pwrState = PWR_OFF;
            s_next.railOn   = '0;
         end
      endcase

      // the processor keeps the system on through hold-on once the button lets go
      // this also cuts a ramp short, so a half-started system is never left up
      if ((s_reg.pwrState != PWR_OFF) && !pressed && !holdOn) begin
         s_next.pwrState              = PWR_OFF;
         s_next.railOn                = '0;
         s_next.step                  = 3'h0;
         s_next.stepCnt               = 32'h0;
         events[`IRQ_POWERED_DOWN]    = 1'b1;
      end

      // long press: counts held cycles and fires once per press
      // the count stops at the threshold, so a press held for minutes fires once
      if (pressed) begin
         if (s_reg.pressCnt != LONG_PRESS_CYCLES) begin
            s_next.pressCnt = s_reg.pressCnt + 32'h1;
         end else if (!s_reg.pressFired) begin
            s_next.pressFired           = 1'b1;
            events[`IRQ_LONG_PRESS]     = 1'b1;
            if (s_reg.ctrl.longPressEn) begin
               s_next.pulseCnt = LONG_PULSE_CYCLES;
            end
         end
      end else begin
         // letting go rearms the detector for the next press
         s_next.pressCnt   = 32'h0;
         s_next.pressFired = 1'b0;
      end

      // the pulse runs out on its own even if the button is let go
      // it pulls power-good low on top of any fault, never instead of one
      if (s_reg.pulseCnt != 32'h0) begin
         s_next.pulseCnt = s_reg.pulseCnt - 32'h1;
      end

      // edge events
      // a press during start-up still flags an event; software may ignore it
      s_next.prevPressed = pressed;
      s_next.prevOkRel   = okReleased;
      if (pressed && !s_reg.prevPressed) begin
         events[`IRQ_BUTTON_PRESS] = 1'b1;
      end
      if (!okReleased && s_reg.prevOkRel) begin
         events[`IRQ_SUPPLY_FAULT] = 1'b1;
      end

      // open-drain enables and led select, registered so no decode glitch reaches a pad
      s_next.echoOe     = pressed;

      // power-good: a held timer, or the long-press pulse while it runs
      s_next.supplyOkOe = !okReleased || (s_reg.pulseCnt != 32'h0);

      // reset follows its own timer, which shares the delay selection
      s_next.resetOe    = !rstReleased;

      // the two selects are complements, so one resistor serves both sinks
      s_next.ledSelA    = s_reg.ctrl.ledLevel;
      s_next.ledSelB    = !s_reg.ctrl.ledLevel;

      // register writes
      if (regWrite) begin
         unique case (regAddr)
            `OFS_CTRL: begin
               s_next.ctrl = ctrl_type'(regWrData[`CTRL_WIDTH-1:0]);
            end
            `OFS_FAULT_MASK: begin
               s_next.faultMask = regWrData[`RAIL_COUNT-1:0];
            end
            `OFS_IRQ_STATUS: begin
               // write one to clear; a new event still wins below
               irqClear = regWrData[`IRQ_COUNT-1:0];
            end
            `OFS_IRQ_MASK: begin
               s_next.irqMask = regWrData[`IRQ_COUNT-1:0];
            end
            default: begin
               // status is read-only, so its writes end here and are dropped
               s_next.ctrl = s_reg.ctrl;
            end
         endcase
      end

      // sticky status: a new event wins over a clear in the same cycle
      // so an event in the cycle of a clear is never lost
      s_next.irqStatus = (s_reg.irqStatus & ~irqClear) | events;

      // register reads, unmapped offsets read zero
      // reads have no side effects, so polling never clears a status bit
      if (regRead) begin
         unique case (regAddr)
            `OFS_CTRL: begin
               s_next.rdata = {28'h0, s_reg.ctrl};
            end
            `OFS_FAULT_MASK: begin
               s_next.rdata = {27'h0, s_reg.faultMask};
            end
            `OFS_STATUS: begin
               s_next.rdata = statusWord;
            end
            `OFS_IRQ_STATUS: begin
               s_next.rdata = {27'h0, s_reg.irqStatus};
            end
            `OFS_IRQ_MASK: begin
               s_next.rdata = {27'h0, s_reg.irqMask};
            end
            default: begin
               s_next.rdata = 32'h0;
            end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////////////////
   // state register

   // out of reset every rail is off and reset and power-good are both pulled low
   // a reset in mid-run drops every rail at once, without a ramp down
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         s_reg             <= '0;
         s_reg.pwrState    <= PWR_OFF;
         s_reg.ctrl        <= ctrl_type'(`CTRL_RESET);
         s_reg.faultMask   <= `FAULT_MASK_RESET;
         s_reg.irqMask     <= `IRQ_MASK_RESET;
         s_reg.supplyOkOe  <= 1'b1;
         s_reg.resetOe     <= 1'b1;
         // the level bit resets to zero, which picks resistor b
         s_reg.ledSelB     <= 1'b1;
      end else begin
         s_reg <= s_next;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////////////
   // outputs

   // open-drain pins only ever drive low; the enable carries the information
   // the pad must never drive high, or the shared line would fight other drivers
   assign buttonEchoOut  = 1'b0;
   assign supplyOkOut    = 1'b0;
   assign resetOutN      = 1'b0;
   assign buttonEchoOe   = s_reg.echoOe;
   assign supplyOkOe     = s_reg.supplyOkOe;
   assign resetOe        = s_reg.resetOe;
   assign railEnable     = s_reg.railOn;
   assign ledCurrentSetA = s_reg.ledSelA;
   assign ledCurrentSetB = s_reg.ledSelB;
   assign regRdData      = s_reg.rdata;

   ////////////////////////////////////////////////////////////////////////////////////////
   // interrupt

   // the level stays up until software clears the status bit or masks it
   assign irq            = |(s_reg.irqStatus & s_reg.irqMask);

endmodule : pmic_power_on_control

// [bench/poc_asserts.sv]
// port checker for the power-on control block
`timescale 1ns/1ps
`include "pmic_poc_cfg.svh"
module poc_asserts
   import pmic_poc_pkg::*;
(
   input wire logic                   clk_sys,
   input wire logic                   rst,
   input wire logic                   regRead,
   input wire logic [31:0]            regRdData,
   input wire logic                   pushButtonN,
   input wire logic                   holdOn,
   input wire logic                   thresholdLow,
   input wire logic [`RAIL_COUNT-1:0] railFault,
   input wire logic [`RAIL_COUNT-1:0] railEnable,
   input wire logic                   buttonEchoOe,
   input wire logic                   supplyOkOe,
   input wire logic                   resetOe,
   input wire logic                   ledCurrentSetA,
   input wire logic                   ledCurrentSetB
);
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (rst);
   ////////////////////////////////////////////////////////////////////////////////
   // echo pin: a steady level wins, a short glitch never reaches the pin
   a_echo_pressed: assert property (!pushButtonN [*8] |-> buttonEchoOe)
      else $error("echo not pulled low during a long press");
   a_echo_released: assert property (pushButtonN [*8] |-> !buttonEchoOe)
      else $error("echo still pulled low after release");
   a_echo_filter: assert property ($rose(buttonEchoOe) |->
      !$past(pushButtonN, 2) && !$past(pushButtonN, 5))
      else $error("echo rose before the filter interval");
   ////////////////////////////////////////////////////////////////////////////////
   // rails come up one at a time from rail 0 and drop together
   a_ramp_order: assert property (railEnable != $past(railEnable) && railEnable != '0
      |-> railEnable == {$past(railEnable[3:0]), 1'b1})
      else $error("rail enabled out of order");
   a_rails_off: assert property ((pushButtonN && !holdOn) [*8] |=> railEnable == '0)
      else $error("rails on without button or hold-on");
   ////////////////////////////////////////////////////////////////////////////////
   // reset and power-good pins, led select and read data; the minimum delay is the shortest selection
   a_reset_hold: assert property (thresholdLow [*3] |-> resetOe)
      else $error("reset released while threshold low");
   a_reset_delay: assert property ($fell(resetOe) |-> !$past(thresholdLow, 1)
      && !$past(thresholdLow, 2) && !$past(thresholdLow, 3))
      else $error("reset released without its delay");
   a_ok_with_reset: assert property ($fell(resetOe) && railFault == '0
      && $stable(railFault) |-> !supplyOkOe)
      else $error("power-good delay differs from reset delay");
   a_ok_pulse: assert property ($rose(supplyOkOe) && &railEnable |=> supplyOkOe [*4])
      else $error("power-good low pulse too short");
   a_led_select: assert property (ledCurrentSetA == !ledCurrentSetB)
      else $error("both or no current-set resistors selected");
   a_read_idle: assert property (!$past(regRead) |-> regRdData == '0)
      else $error("read data outside its cycle");
endmodule : poc_asserts

// [bench/poc_partner.sv]
// model of the push-button and of the processor hold-on line
`timescale 1ns/1ps
module poc_partner
   import pmic_poc_pkg::*;
(
   input  wire logic       clk_sys,
   input  wire logic       rst,
   input  wire logic       pressReq,
   input  wire logic       allowHold,
   input  wire logic [4:0] railEnable,
   output      logic       pushButtonN,
   output      logic       holdOn
);
   // hold-on only rises once every rail is up, as a booted processor would do it
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         pushButtonN <= 1'b1;
         holdOn      <= 1'b0;
      end else begin
         pushButtonN <= !pressReq; // pull-up level when released
         holdOn      <= allowHold && (holdOn || railEnable == 5'h1F);
      end
   end
endmodule : poc_partner

// [bench/testbench.sv]
// self-checking bench for the power-on control block
`timescale 1ns/1ps
`include "pmic_poc_cfg.svh"
`define CHECK_EQ(a, b) begin total_checks++; if ((a) !== (b)) begin fail_count++; \
   $display("BAD t=%0t got %h exp %h", $time, (a), (b)); end end
module testbench
   import pmic_poc_pkg::*;
;
   logic        clk_sys = 1'b0;
   logic        rst = 1'b1;
   logic [7:0]  regAddr = 8'h00;
   logic [31:0] regWrData = 32'h0;
   logic        regWrite = 1'b0;
   logic        regRead = 1'b0;
   logic [31:0] regRdData, d;
   logic        pushButtonN, holdOn, pressReq = 1'b0, allowHold = 1'b0;
   logic        thresholdLow = 1'b0;
   logic [4:0]  railFault = 5'h00, railEnable;
   logic        buttonEchoOut, buttonEchoOe, supplyOkOut, supplyOkOe, resetOutN, resetOe;
   logic        ledCurrentSetA, ledCurrentSetB, irq;
   int          fail_count = 0, total_checks = 0, s, n, t[4];
   // short counts keep the run brief; the longer release delays keep their real length
   pmic_power_on_control #(.DEBOUNCE_CYCLES(4), .SEQ_STEP_CYCLES(3), .LONG_PRESS_CYCLES(20),
      .LONG_PULSE_CYCLES(5), .DELAY0_CYCLES(2)) dut_u (.clk_sys, .rst, .regAddr, .regWrData,
      .regWrite, .regRead, .regRdData, .pushButtonN, .holdOn, .thresholdLow, .railFault,
      .railEnable, .buttonEchoOut, .buttonEchoOe, .supplyOkOut, .supplyOkOe, .resetOutN,
      .resetOe, .ledCurrentSetA, .ledCurrentSetB, .irq);
   poc_partner partner_u (.clk_sys, .rst, .pressReq, .allowHold, .railEnable, .pushButtonN,
      .holdOn);
   ////////////////////////////////////////////////////////////////////////////////
   // clock and watchdog; a hang counts as a mismatch
   always #4 clk_sys = ~clk_sys;
   initial begin
      #(8 * 20000);
      fail_count++;
      give_verdict();
   end
   task tick();
      @(posedge clk_sys);
      #1;
   endtask : tick
   task wr(input logic [7:0] a, input logic [31:0] v);
      @(posedge clk_sys);
      regAddr   <= a;
      regWrData <= v;
      regWrite  <= 1'b1;
      @(posedge clk_sys);
      regWrite  <= 1'b0;
   endtask : wr
   // read data stand only in the cycle after the strobe
   task rd(input logic [7:0] a, output logic [31:0] v);
      @(posedge clk_sys);
      regAddr <= a;
      regRead <= 1'b1;
      @(posedge clk_sys);
      regRead <= 1'b0;
      #1;
      v = regRdData;
   endtask : rd
   // press, follow the ramp, time reset release from the last rail, then let go
   task pwr_up(output int c);
      int i;
      @(posedge clk_sys);
      pressReq  <= 1'b1;
      allowHold <= 1'b1;
      for (i = 0; i < 40 && railEnable === 5'h00; i++) tick();
      for (i = 1; i < 5; i++) begin
         repeat (3) tick();
         `CHECK_EQ(railEnable, 5'((1 << (i + 1)) - 1))
      end
      `CHECK_EQ(buttonEchoOe, 1'b1)
      for (c = 0; c < 60 && resetOe !== 1'b0; c++) tick();
      `CHECK_EQ(supplyOkOe, resetOe)
      @(posedge clk_sys);
      pressReq <= 1'b0;
      repeat (12) tick();
      `CHECK_EQ(railEnable, 5'h1F)
      `CHECK_EQ(buttonEchoOe, 1'b0)
   endtask : pwr_up
   task pwr_down();
      @(posedge clk_sys);
      allowHold <= 1'b0;
      repeat (5) tick();
      `CHECK_EQ(railEnable, 5'h00)
      `CHECK_EQ(resetOe, 1'b1)
   endtask : pwr_down
   ////////////////////////////////////////////////////////////////////////////////
   // main sequence
   initial begin
      repeat (10) @(posedge clk_sys);
      rst <= 1'b0;
      #1;
      `CHECK_EQ({railEnable, supplyOkOe, resetOe, ledCurrentSetB}, 8'h07)
      `CHECK_EQ({buttonEchoOut, supplyOkOut, resetOutN}, 3'h0)
      rd(`OFS_FAULT_MASK, d);
      `CHECK_EQ(d, 32'h1F)
      rd(8'h40, d);
      `CHECK_EQ(d, 32'h0)
      @(posedge clk_sys);
      pressReq <= 1'b1;
      repeat (3) @(posedge clk_sys);
      pressReq <= 1'b0;
      repeat (8) tick();
      `CHECK_EQ({buttonEchoOe, railEnable}, 6'h00)
      for (s = 0; s < 4; s++) begin
         wr(`OFS_CTRL, 32'(s << 1));
         pwr_up(t[s]);
         `CHECK_EQ(t[s], (s == 0) ? 6 : 60)
         pwr_down();
      end
      wr(`OFS_CTRL, 32'h0);
      pwr_up(n);
      rd(`OFS_STATUS, d);
      `CHECK_EQ(d[1:0], 2'h2)
      rd(`OFS_IRQ_STATUS, d);
      `CHECK_EQ(d, 32'h1F)
      wr(`OFS_FAULT_MASK, 32'h02);
      wr(`OFS_IRQ_MASK, 32'h08);
      wr(`OFS_IRQ_STATUS, 32'h1F);
      @(posedge clk_sys);
      railFault <= 5'h01;
      repeat (12) tick();
      `CHECK_EQ({supplyOkOe, irq}, 2'h0)
      @(posedge clk_sys);
      railFault <= 5'h02;
      repeat (3) tick();
      `CHECK_EQ({supplyOkOe, irq}, 2'h3)
      @(posedge clk_sys);
      railFault <= 5'h00;
      wr(`OFS_IRQ_STATUS, 32'h08);
      repeat (6) tick();
      `CHECK_EQ({supplyOkOe, irq}, 2'h0)
      for (s = 0; s < 2; s++) begin
         wr(`OFS_CTRL, 32'(s));
         wr(`OFS_IRQ_STATUS, 32'h1F);
         @(posedge clk_sys);
         pressReq <= 1'b1;
         n = 0;
         repeat (60) begin
            tick();
            n += supplyOkOe;
         end
         `CHECK_EQ(n, 5 * s)
         rd(`OFS_IRQ_STATUS, d);
         `CHECK_EQ(d[2], 1'b1)
         @(posedge clk_sys);
         pressReq <= 1'b0;
         repeat (8) tick();
      end
      @(posedge clk_sys);
      thresholdLow <= 1'b1;
      repeat (4) tick();
      `CHECK_EQ({resetOe, supplyOkOe}, 2'h2)
      @(posedge clk_sys);
      thresholdLow <= 1'b0;
      repeat (12) tick();
      `CHECK_EQ(resetOe, 1'b0)
      for (s = 0; s < 2; s++) begin
         wr(`OFS_CTRL, 32'(s << 3));
         repeat (2) tick();
         `CHECK_EQ({ledCurrentSetA, ledCurrentSetB}, 2'(1 + s))
      end
      pwr_down();
      give_verdict();
   end
   task give_verdict();
      $display("checks %0d mismatches %0d", total_checks, fail_count);
      if (fail_count == 0 && total_checks > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask : give_verdict
endmodule : testbench
bind pmic_power_on_control poc_asserts chk_u (.clk_sys, .rst, .regRead, .regRdData,
   .pushButtonN, .holdOn, .thresholdLow, .railFault, .railEnable, .buttonEchoOe,
   .supplyOkOe, .resetOe, .ledCurrentSetA, .ledCurrentSetB);
